// *** verilog/gbr_consts.svh ***
`ifndef GBR_CONSTS_SVH
`define GBR_CONSTS_SVH
// Command codes on the host link (16 bits, arbitrary values).
`define GBR_CMD_WRITE    16'h0101
`define GBR_CMD_READ     16'h0102
`define GBR_CMD_START    16'h0103
// Packet error code generator and seed.
`define GBR_PEC_POLY     15'h4599
`define GBR_PEC_SEED     15'h0010
// Frame lengths in host clocks or bytes, last transfer slot and buffer reset value.
`define GBR_HDR_LAST     7'd31
`define GBR_WR_BITS      7'd96
`define GBR_RD_BYTES     4'd8
`define GBR_DATA_BYTES   4'd6
`define GBR_LAST_SLOT    2'd2
`define GBR_BUF_RESET    8'hff
// Pin indices: three = sub chip select, four = data/SDA, five = clock/SCL.
`define GBR_PIN_CS       0
`define GBR_PIN_DAT      1
`define GBR_PIN_CLK      2
// I2C codes.
`define GBR_I2C_START    4'h6
`define GBR_I2C_STOP     4'h1
`define GBR_I2C_BLANK    4'h0
`define GBR_I2C_NOTX     4'h7
`define GBR_I2C_ACK      4'h0
`define GBR_I2C_NACK     4'h8
`define GBR_I2C_NACK_STP 4'h9
`define GBR_RB_SLV_ACK   4'h7
`define GBR_RB_SLV_NACK  4'hf
`define GBR_RB_ACK_STP   4'h1
`define GBR_RB_NACK_STP  4'h9
// SPI codes.
`define GBR_SPI_CS_LOW   4'h8
`define GBR_SPI_CS_FALL  4'ha
`define GBR_SPI_CS_HIGH  4'h9
`define GBR_SPI_RB_PRE   4'h7
`define GBR_SPI_RB_POST  4'hf
// Half-step positions inside one 48-edge byte slot.
`define GBR_H_STA_SCL_HI 6'd1
`define GBR_H_STA_SDA_LO 6'd3
`define GBR_H_STA_SCL_LO 6'd5
`define GBR_H_STP_SDA_LO 6'd1
`define GBR_H_STP_SCL_HI 6'd2
`define GBR_H_STP_SDA_HI 6'd4
`define GBR_H_CS_FALL    6'd2
`define GBR_H_BIT0       6'd6
`define GBR_H_SPI_END    6'd38
`define GBR_H_I2C_END    6'd42
`define GBR_H_POST_SCL   6'd44
`define GBR_H_POST_SDA   6'd46
`define GBR_H_LAST       6'd47
// Watchdog: time in seconds and clock rate in hertz.
`define GBR_WDT_TIME_S   2
`define GBR_CLK_HZ       200000000
`endif

// *** verilog/gbr_pkg.sv ***
package gbr_pkg;
  // Host frame states, Gray coded in the order listed: idle, header, write, read, transfer, skip.
  typedef enum logic [2:0] {
    F_IDLE = 3'h0,
    F_HDR  = 3'h1,
    F_WR   = 3'h3,
    F_RD   = 3'h2,
    F_XF   = 3'h6,
    F_SKIP = 3'h7
  } gbr_frame_t;

  // Whole state of the bridge.
  typedef struct packed {
    logic [1:0]       sck_sy;
    logic             sck_d;
    logic [1:0]       cs_sy;
    logic             cs_d;
    logic [1:0]       mosi_sy;
    logic [2:0]       pin_s1;
    logic [2:0]       pin_s2;
    gbr_frame_t       fst;
    logic [6:0]       bitcnt;
    logic [63:0]      rx_sr;
    logic [0:5][7:0]  buffer;
    logic [1:0][7:0]  fmem;
    logic             fwp;
    logic             frp;
    logic [1:0]       fcnt;
    logic [3:0]       pidx;
    logic [7:0]       out_sr;
    logic [2:0]       out_cnt;
    logic             miso;
    logic [1:0]       slot;
    logic [5:0]       half;
    logic             spi_mode;
    logic             skip;
    logic             ack;
    logic [7:0]       rxd;
    logic [3:0]       pre_rb;
    logic [2:0]       oe;
    logic [2:0]       drv_o;
    logic [28:0]      wdt;
  } gbr_state_t;
endpackage : gbr_pkg

// *** verilog/gbr_bridge.sv ***
`timescale 1ns/1ps
`include "gbr_consts.svh"

module gbr_bridge #(
  parameter int unsigned WDT_CYCLES = `GBR_WDT_TIME_S * `GBR_CLK_HZ
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic host_sck,
  input  wire logic host_chip_select_n,
  input  wire logic host_data_in,
  output logic      host_data_out,
  input  wire logic aux_pin_three_i,
  output logic      aux_pin_three_o,
  output logic      aux_pin_three_oe,
  input  wire logic aux_pin_four_i,
  output logic      aux_pin_four_o,
  output logic      aux_pin_four_oe,
  input  wire logic aux_pin_five_i,
  output logic      aux_pin_five_o,
  output logic      aux_pin_five_oe
);

  // ----------------------------------------------------------------
  // Packet error code
  // ----------------------------------------------------------------

  // Runs the code generator over the top n bits of d, MSB first.
  function automatic logic [14:0] pec_calc(input logic [47:0] d, input logic [5:0] n);
    logic [14:0] c;
    logic        fb;
    c = `GBR_PEC_SEED;
    for (int i = 0; i < 48; i++) begin
      if (6'(i) < n) begin
        fb = d[47-i] ^ c[14];
        c  = {c[13:0], 1'b0} ^ (fb ? `GBR_PEC_POLY : 15'h0000);
      end
    end
    return c;
  endfunction : pec_calc

  // ----------------------------------------------------------------
  // State and derived signals
  // ----------------------------------------------------------------

  gbr_pkg::gbr_state_t s_ff;     // Registered state.
  gbr_pkg::gbr_state_t nxt_s;    // Next state.

  logic        sck_rise;         // Host clock rising edge seen.
  logic        sck_fall;         // Host clock falling edge seen.
  logic        cs_rise;          // Host chip select released.
  logic        cs_low;           // Host frame in progress.
  logic [63:0] rx_next;          // Receive shifter after this bit.
  logic [15:0] hdr_pec;          // Expected header code.
  logic        hdr_ok;           // Header code matches.
  logic [15:0] rd_pec;           // Code appended to a buffer read.
  logic [15:0] wr_pec;           // Expected code of a buffer write.
  logic [2:0]  idx;              // Byte holding the slot's pre code.
  logic [3:0]  pre;              // Current slot pre-byte code.
  logic [3:0]  post;             // Current slot post-byte code.
  logic [7:0]  data;             // Current slot data byte.
  logic [5:0]  hm;               // Half-step counted from bit 0.
  logic [3:0]  bj;               // Bit number inside the slot.
  logic [1:0]  ph;               // Phase inside one master clock.
  logic        tx_bit;           // Data bit being sent.
  logic        push;             // Producer writes the read buffer.
  logic        pop;              // Link shifter takes a byte.
  logic [7:0]  push_byte;        // Byte offered to the read buffer.

  // Edges are found on the second synchroniser stage only.
  assign sck_rise = s_ff.sck_sy[1] & ~s_ff.sck_d;
  assign sck_fall = ~s_ff.sck_sy[1] & s_ff.sck_d;
  assign cs_rise  = s_ff.cs_sy[1] & ~s_ff.cs_d;
  assign cs_low   = ~s_ff.cs_sy[1];
  assign rx_next  = {s_ff.rx_sr[62:0], s_ff.mosi_sy[1]};
  assign hdr_pec  = {pec_calc({rx_next[31:16], 32'h0000_0000}, 6'd16), 1'b0};
  assign hdr_ok   = (rx_next[15:0] == hdr_pec);
  assign rd_pec   = {pec_calc(s_ff.buffer, 6'd48), 1'b0};
  assign wr_pec   = {pec_calc(s_ff.rx_sr[63:16], 6'd48), 1'b0};

  // Slot fields; byte pairs hold pre code, data, post code.
  assign idx  = {s_ff.slot, 1'b0};
  assign pre  = s_ff.buffer[idx][7:4];
  assign data = {s_ff.buffer[idx][3:0], s_ff.buffer[{s_ff.slot, 1'b1}][7:4]};
  assign post = s_ff.buffer[{s_ff.slot, 1'b1}][3:0];
  assign hm   = s_ff.half - `GBR_H_BIT0;
  assign bj   = hm[5:2];
  assign ph   = hm[1:0];
  assign tx_bit = data[3'd7 - bj[2:0]];

  // The read buffer only fills while it has room; a slow link stalls it.
  assign push = (s_ff.fst == gbr_pkg::F_RD) && (s_ff.pidx < `GBR_RD_BYTES) &&
                (s_ff.fcnt != 2'd2);
  assign pop  = sck_fall && (s_ff.fst == gbr_pkg::F_RD) && (s_ff.out_cnt == 3'd0) &&
                (s_ff.fcnt != 2'd0);
  assign push_byte = (s_ff.pidx < `GBR_DATA_BYTES) ? s_ff.buffer[s_ff.pidx[2:0]] :
                     (s_ff.pidx == `GBR_DATA_BYTES) ? rd_pec[15:8] : rd_pec[7:0];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // One process computes the whole next state from the current one.
  always_comb begin
    nxt_s = s_ff;
    // Two flip-flops on every pin and host line before use.
    nxt_s.sck_sy  = {s_ff.sck_sy[0], host_sck};
    nxt_s.sck_d   = s_ff.sck_sy[1];
    nxt_s.cs_sy   = {s_ff.cs_sy[0], host_chip_select_n};
    nxt_s.cs_d    = s_ff.cs_sy[1];
    nxt_s.mosi_sy = {s_ff.mosi_sy[0], host_data_in};
    nxt_s.pin_s1  = {aux_pin_five_i, aux_pin_four_i, aux_pin_three_i};
    nxt_s.pin_s2  = s_ff.pin_s1;

    // Watchdog counts up to WDT_CYCLES and holds there until a command restarts it.
    if (s_ff.wdt < 29'(WDT_CYCLES)) begin
      nxt_s.wdt = s_ff.wdt + 29'h0000001;
    end

    // Host bits are taken on rising edges while selected.
    if (sck_rise && cs_low) begin
      nxt_s.rx_sr  = rx_next;
      nxt_s.bitcnt = (s_ff.bitcnt == 7'h7f) ? s_ff.bitcnt : s_ff.bitcnt + 7'h01;
    end

    // Read buffer: two entries, producer and link shifter.
    if (push) begin
      nxt_s.fmem[s_ff.fwp] = push_byte;
      nxt_s.fwp  = ~s_ff.fwp;
      nxt_s.pidx = s_ff.pidx + 4'h1;
    end
    if (pop) begin
      nxt_s.frp = ~s_ff.frp;
    end
    nxt_s.fcnt = s_ff.fcnt + {1'b0, push} - {1'b0, pop};

    unique case (s_ff.fst)
      // Wait for the host to select the device.
      gbr_pkg::F_IDLE: begin
        if (cs_low) begin
          nxt_s.fst    = gbr_pkg::F_HDR;
          nxt_s.bitcnt = 7'h00;
        end
      end
      // Command word and its code; a bad code drops the frame.
      gbr_pkg::F_HDR: begin
        if (sck_rise && cs_low && s_ff.bitcnt == `GBR_HDR_LAST) begin
          nxt_s.fst = gbr_pkg::F_SKIP;
          if (hdr_ok) begin
            nxt_s.wdt = 29'h0000000;
            unique case (rx_next[31:16])
              `GBR_CMD_WRITE: nxt_s.fst = gbr_pkg::F_WR;
              `GBR_CMD_READ: nxt_s.fst = gbr_pkg::F_RD;
              `GBR_CMD_START: begin
                nxt_s.spi_mode = s_ff.buffer[0][7];
                nxt_s.fst      = gbr_pkg::F_XF;
                nxt_s.slot     = 2'd0;
                nxt_s.half     = 6'd0;
                nxt_s.skip     = 1'b0;
                nxt_s.rxd      = 8'h00;
              end
              default: nxt_s.fst = gbr_pkg::F_SKIP;
            endcase
          end
        end
      end
      // Buffer write collects bits; commit happens on release.
      gbr_pkg::F_WR: begin
      end
      // Buffer read: bytes leave MSB first on falling edges.
      gbr_pkg::F_RD: begin
        if (sck_fall) begin
          if (s_ff.out_cnt != 3'd0) begin
            nxt_s.miso    = s_ff.out_sr[7];
            nxt_s.out_sr  = {s_ff.out_sr[6:0], 1'b0};
            nxt_s.out_cnt = s_ff.out_cnt - 3'd1;
          end else if (pop) begin
            nxt_s.miso    = s_ff.fmem[s_ff.frp][7];
            nxt_s.out_sr  = {s_ff.fmem[s_ff.frp][6:0], 1'b0};
            nxt_s.out_cnt = 3'd7;
          end else begin
            nxt_s.miso = 1'b1;
          end
        end
      end
      // Transfer: every host edge is one half-step of the master.
      // two host clocks
      gbr_pkg::F_XF: begin
        if ((sck_rise || sck_fall) && cs_low) begin
          if (s_ff.spi_mode && !s_ff.skip) begin
            if (s_ff.half == 6'd0) begin
              unique case (pre)
                `GBR_SPI_CS_LOW: nxt_s.oe[`GBR_PIN_CS] = 1'b1;
                `GBR_SPI_CS_FALL: nxt_s.oe[`GBR_PIN_CS] = 1'b0;
                default: begin
                  nxt_s.oe   = 3'b000;
                  nxt_s.skip = 1'b1;
                end
              endcase
            end
            if (s_ff.half == `GBR_H_CS_FALL && pre == `GBR_SPI_CS_FALL) begin
              nxt_s.oe[`GBR_PIN_CS] = 1'b1;
            end
            if (s_ff.half >= `GBR_H_BIT0 && s_ff.half < `GBR_H_SPI_END) begin
              unique case (ph)
                2'd0: begin
                  nxt_s.oe[`GBR_PIN_CLK] = 1'b1;
                  nxt_s.oe[`GBR_PIN_DAT] = ~tx_bit;
                end
                2'd1: nxt_s.oe[`GBR_PIN_CLK] = 1'b1;
                2'd2: nxt_s.oe[`GBR_PIN_CLK] = 1'b0;
                2'd3: nxt_s.rxd = {s_ff.rxd[6:0], s_ff.pin_s2[`GBR_PIN_DAT]};
              endcase
            end
            if (s_ff.half == `GBR_H_SPI_END) begin
              nxt_s.oe[`GBR_PIN_DAT] = 1'b0;
            end
            if (s_ff.half == `GBR_H_POST_SCL && post == `GBR_SPI_CS_HIGH) begin
              nxt_s.oe[`GBR_PIN_CS] = 1'b0;
            end
          end else if (!s_ff.skip) begin
            if (s_ff.half == 6'd0) begin
              unique case (pre)
                `GBR_I2C_START: begin
                  nxt_s.oe[`GBR_PIN_DAT] = 1'b0;
                  nxt_s.pre_rb = `GBR_I2C_START;
                end
                `GBR_I2C_STOP: begin
                  nxt_s.oe[`GBR_PIN_CLK] = 1'b1;
                  nxt_s.pre_rb = `GBR_I2C_STOP;
                end
                `GBR_I2C_BLANK: begin
                  nxt_s.pre_rb = s_ff.oe[`GBR_PIN_DAT] ? `GBR_I2C_BLANK : `GBR_I2C_NOTX;
                end
                default: begin
                  nxt_s.oe[2:1] = 2'b00;
                  nxt_s.skip    = 1'b1;
                  nxt_s.pre_rb  = `GBR_I2C_NOTX;
                end
              endcase
            end
            if (pre == `GBR_I2C_START) begin
              if (s_ff.half == `GBR_H_STA_SCL_HI) nxt_s.oe[`GBR_PIN_CLK] = 1'b0;
              if (s_ff.half == `GBR_H_STA_SDA_LO) nxt_s.oe[`GBR_PIN_DAT] = 1'b1;
              if (s_ff.half == `GBR_H_STA_SCL_LO) nxt_s.oe[`GBR_PIN_CLK] = 1'b1;
            end
            if (pre == `GBR_I2C_STOP) begin
              if (s_ff.half == `GBR_H_STP_SDA_LO) nxt_s.oe[`GBR_PIN_DAT] = 1'b1;
              if (s_ff.half == `GBR_H_STP_SCL_HI) nxt_s.oe[`GBR_PIN_CLK] = 1'b0;
              if (s_ff.half == `GBR_H_STP_SDA_HI) begin
                nxt_s.oe[`GBR_PIN_DAT] = 1'b0;
                nxt_s.skip = 1'b1;
              end
            end
            // Eight data bits and the ninth clock.
            if (s_ff.half >= `GBR_H_BIT0 && s_ff.half < `GBR_H_I2C_END) begin
              unique case (ph)
                2'd0: nxt_s.oe[`GBR_PIN_CLK] = 1'b1;
                2'd1: nxt_s.oe[`GBR_PIN_DAT] = bj[3] ? (post == `GBR_I2C_ACK) : ~tx_bit;
                2'd2: nxt_s.oe[`GBR_PIN_CLK] = 1'b0;
                2'd3: begin
                  if (bj[3]) nxt_s.ack = s_ff.pin_s2[`GBR_PIN_DAT];
                  else nxt_s.rxd = {s_ff.rxd[6:0], s_ff.pin_s2[`GBR_PIN_DAT]};
                end
              endcase
            end
            if (s_ff.half == `GBR_H_I2C_END) begin
              nxt_s.oe[`GBR_PIN_CLK] = 1'b1;
            end
            if (post == `GBR_I2C_NACK_STP) begin
              if (s_ff.half == `GBR_H_I2C_END + 6'd1) nxt_s.oe[`GBR_PIN_DAT] = 1'b1;
              if (s_ff.half == `GBR_H_POST_SCL) nxt_s.oe[`GBR_PIN_CLK] = 1'b0;
              if (s_ff.half == `GBR_H_POST_SDA) nxt_s.oe[`GBR_PIN_DAT] = 1'b0;
            end
          end
          if (s_ff.half == `GBR_H_LAST) begin
            if (s_ff.spi_mode) begin
              nxt_s.buffer[idx][7:4] = `GBR_SPI_RB_PRE;
              if (!s_ff.skip) begin
                nxt_s.buffer[idx][3:0] = s_ff.rxd[7:4];
                nxt_s.buffer[{s_ff.slot, 1'b1}] = {s_ff.rxd[3:0], `GBR_SPI_RB_POST};
              end
            end else begin
              nxt_s.buffer[idx][7:4] = s_ff.pre_rb;
              if (!s_ff.skip) begin
                nxt_s.buffer[idx][3:0] = s_ff.rxd[7:4];
                nxt_s.buffer[{s_ff.slot, 1'b1}][7:4] = s_ff.rxd[3:0];
                if (post == `GBR_I2C_ACK) begin
                  nxt_s.buffer[{s_ff.slot, 1'b1}][3:0] = `GBR_I2C_ACK;
                end else if (post == `GBR_I2C_NACK_STP) begin
                  nxt_s.buffer[{s_ff.slot, 1'b1}][3:0] =
                    s_ff.ack ? `GBR_RB_NACK_STP : `GBR_RB_ACK_STP;
                end else begin
                  nxt_s.buffer[{s_ff.slot, 1'b1}][3:0] =
                    s_ff.ack ? `GBR_RB_SLV_NACK : `GBR_RB_SLV_ACK;
                end
              end
            end
            nxt_s.half = 6'd0;
            nxt_s.skip = 1'b0;
            nxt_s.rxd  = 8'h00;
            nxt_s.slot = s_ff.slot + 2'd1;
            if (s_ff.slot == `GBR_LAST_SLOT) begin
              nxt_s.fst = gbr_pkg::F_SKIP;
            end
          end else begin
            nxt_s.half = s_ff.half + 6'd1;
          end
        end
      end
      // Ignore the rest of the frame.
      gbr_pkg::F_SKIP: begin
      end
      default: nxt_s.fst = gbr_pkg::F_IDLE;
    endcase

    // Release ends every frame; a write commits or poisons the buffer.
    if (cs_rise) begin
      if (s_ff.fst == gbr_pkg::F_WR) begin
        if (s_ff.bitcnt == `GBR_WR_BITS && s_ff.rx_sr[15:0] == wr_pec) begin
          nxt_s.buffer = s_ff.rx_sr[63:16];
        end else begin
          nxt_s.buffer = {6{`GBR_BUF_RESET}};
        end
      end
      nxt_s.fst     = gbr_pkg::F_IDLE;
      nxt_s.fcnt    = 2'd0;
      nxt_s.fwp     = 1'b0;
      nxt_s.frp     = 1'b0;
      nxt_s.pidx    = 4'h0;
      nxt_s.out_cnt = 3'd0;
      nxt_s.miso    = 1'b1;
    end

    if (s_ff.wdt == 29'(WDT_CYCLES - 1)) begin
      nxt_s.oe = 3'b000;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Pins are released and the buffer reads all ones after reset.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff        <= '0;
      s_ff.sck_sy <= 2'b11;
      s_ff.sck_d  <= 1'b1;
      s_ff.cs_sy  <= 2'b11;
      s_ff.cs_d   <= 1'b1;
      s_ff.pin_s1 <= 3'b111;
      s_ff.pin_s2 <= 3'b111;
      s_ff.buffer <= {6{`GBR_BUF_RESET}};
      s_ff.miso   <= 1'b1;
      s_ff.fst    <= gbr_pkg::F_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Open-drain pins: outputs only ever pull low.
  assign host_data_out    = s_ff.miso;
  assign aux_pin_three_o  = s_ff.drv_o[`GBR_PIN_CS];
  assign aux_pin_three_oe = s_ff.oe[`GBR_PIN_CS];
  assign aux_pin_four_o   = s_ff.drv_o[`GBR_PIN_DAT];
  assign aux_pin_four_oe  = s_ff.oe[`GBR_PIN_DAT];
  assign aux_pin_five_o   = s_ff.drv_o[`GBR_PIN_CLK];
  assign aux_pin_five_oe  = s_ff.oe[`GBR_PIN_CLK];

endmodule : gbr_bridge

// *** bench/gbr_bridge_properties.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Pin-level checker for the bridge.
// ----------------------------------------
module gbr_bridge_properties #(
  parameter int unsigned WDT_CYCLES = 32'h0000_07d0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic host_chip_select_n,
  input wire logic host_data_out,
  input wire logic aux_pin_three_o,
  input wire logic aux_pin_three_oe,
  input wire logic aux_pin_four_o,
  input wire logic aux_pin_four_oe,
  input wire logic aux_pin_five_o,
  input wire logic aux_pin_five_oe
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Host idle long enough to clear the 2FF sync.
  sequence host_idle;
    host_chip_select_n [*6];
  endsequence

  // Master clock pin starts pulling low.
  sequence clk_pulled;
    $rose(aux_pin_five_oe);
  endsequence

  pin_low_only_a: assert property (!aux_pin_three_o && !aux_pin_four_o && !aux_pin_five_o)
    else $error("pin driven high");
  pins_kept_a: assert property (host_idle |=> !$rose(aux_pin_three_oe) &&
    !$rose(aux_pin_four_oe) && !$rose(aux_pin_five_oe))
    else $error("pin pulled while host idle");
  out_idle_a: assert property (host_idle |-> host_data_out)
    else $error("link output not idle high");
  reset_rel_a: assert property ($rose(rst_n) |-> !aux_pin_three_oe &&
    !aux_pin_four_oe && !aux_pin_five_oe && host_data_out)
    else $error("pins not at default after reset");
  // Low and high phases each span a whole host clock period.
  clk_low_width_a: assert property (clk_pulled |=> aux_pin_five_oe [*7])
    else $error("master clock low too short");
  clk_high_width_a: assert property ($fell(aux_pin_five_oe) |=> !aux_pin_five_oe [*7])
    else $error("master clock high too short");
  // Select moves only while the master clock idles high.
  cs_fall_idle_a: assert property ($rose(aux_pin_three_oe) |-> !aux_pin_five_oe)
    else $error("select fell with clock low");
  cs_rise_idle_a: assert property ($fell(aux_pin_three_oe) |-> !aux_pin_five_oe)
    else $error("select rose with clock low");
endmodule : gbr_bridge_properties

// *** bench/gbr_sub_slave.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Mode 3 slave answering on the shared data pin.
// ----------------------------------------
module gbr_sub_slave #(
  parameter logic [7:0] REPLY = 8'ha5
) (
  input  wire logic sel_n,
  input  wire logic sclk,
  output logic      pull_low
);
  logic [2:0] rise_cnt;  // Rising clock edges seen.
  logic [2:0] idx;       // Bit now presented.

  always @(posedge sclk or posedge sel_n) begin
    if (sel_n) begin
      rise_cnt <= 3'h0;
    end else begin
      rise_cnt <= rise_cnt + 3'h1;
    end
  end

  always @(negedge sclk or posedge sel_n) begin
    if (sel_n) begin
      idx <= 3'h0;
    end else begin
      idx <= rise_cnt;
    end
  end

  assign pull_low = !sel_n && !REPLY[3'h7 - idx];
endmodule : gbr_sub_slave

// *** bench/tb.sv ***
`timescale 1ns/1ps
`include "gbr_consts.svh"
// ----------------------------------------
// Bench top: link driver and buffer checks.
// ----------------------------------------
module tb;
  logic         core_clk = 1'b0;  // System clock.
  logic         rst_n    = 1'b0;  // Reset, active low.
  logic         host_sck = 1'b0;  // Link clock, idles low.
  logic         cs_n     = 1'b1;  // Frame select, active low.
  logic         din      = 1'b0;  // Link data in.
  logic [127:0] rx;               // Bits seen on the link output.
  wire logic    dout;
  wire logic    e3, e4, e5, slv_pull;
  wire logic    p3 = !e3;               // Pulled-up pins.
  wire logic    p4 = !(e4 | slv_pull);
  wire logic    p5 = !e5;
  int           fail_count = 0;
  int           samples_checked = 0;
  int           cycles = 0;

  always #2.5 core_clk = ~core_clk;

  gbr_bridge #(.WDT_CYCLES(2000)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .host_sck(host_sck),
    .host_chip_select_n(cs_n), .host_data_in(din), .host_data_out(dout),
    .aux_pin_three_i(p3), .aux_pin_three_o(), .aux_pin_three_oe(e3),
    .aux_pin_four_i(p4), .aux_pin_four_o(), .aux_pin_four_oe(e4),
    .aux_pin_five_i(p5), .aux_pin_five_o(), .aux_pin_five_oe(e5));

  gbr_sub_slave u_slave (.sel_n(p3), .sclk(p5), .pull_low(slv_pull));

  function automatic logic [15:0] packet_error_code(input logic [63:0] v, input int n);
    logic [14:0] r;
    logic        b;
    r = `GBR_PEC_SEED;
    for (int i = n - 1; i >= 0; i--) begin
      b = v[i] ^ r[14];
      r = {r[13:0], 1'b0} ^ (b ? `GBR_PEC_POLY : 15'h0000);
    end
    return {r, 1'b0};
  endfunction : packet_error_code

  function automatic logic [31:0] hdr(input logic [15:0] c);
    return {c, packet_error_code(64'(c), 16)};
  endfunction : hdr

  // One frame of n bits; output sampled just before each rising edge.
  task automatic frame(input logic [127:0] tx, input int n);
    cs_n = 1'b0;
    #24;
    for (int i = n - 1; i >= 0; i--) begin
      din = tx[i];
      #24;
      rx = {rx[126:0], dout};
      host_sck = 1'b1;
      #24;
      host_sck = 1'b0;
    end
    #24;
    cs_n = 1'b1;
    #96;
  endtask : frame

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [47:0] d, input logic [15:0] bad);
    frame(128'({hdr(`GBR_CMD_WRITE), d, packet_error_code(64'(d), 48) ^ bad}), 96);
  endtask : wr

  task automatic rdchk(input logic [47:0] exp);
    frame(128'({hdr(`GBR_CMD_READ), 64'h0}), 96);
    chk(rx[63:0], {exp, packet_error_code(64'(exp), 48)});
  endtask : rdchk

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // Hang guard: the tests need about 12700 clocks.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      print_verdict();
    end
  end

  initial begin
    #10;
    rst_n = 1'b1;
    #100;
    rdchk({6{8'hff}});
    wr(48'h0123_4567_89ab, 16'h0000);
    rdchk(48'h0123_4567_89ab);
    wr(48'h0123_4567_89ab, 16'h0001);
    rdchk({6{8'hff}});
    $display("test buffer done");
    wr({4'h8, 8'hff, 4'h0, 4'ha, 8'h3c, 4'h9, 4'h8, 8'hff, 4'h0}, 16'h0000);
    frame(128'({hdr(`GBR_CMD_START), 72'h0}), 104);
    chk(64'(e3), 64'h1);
    rdchk({4'h7, 8'ha5, 4'hf, 4'h7, 8'h24, 4'hf, 4'h7, 8'ha5, 4'hf});
    repeat (2100) @(negedge core_clk);
    chk(64'({e3, e4, e5}), 64'h0);
    $display("test spi done");
    wr({4'h6, 8'hc3, 4'h9, 4'h0, 8'h5a, 4'h0, 4'h7, 8'h12, 4'h0}, 16'h0000);
    frame(128'({hdr(`GBR_CMD_START), 72'h0}), 104);
    chk(64'({e4, e5}), 64'h0);
    rdchk({4'h6, 8'hc3, 4'h9, 4'h7, 8'h5a, 4'h0, 4'h7, 8'h12, 4'h0});
    $display("test i2c done");
    print_verdict();
  end
endmodule : tb

bind gbr_bridge gbr_bridge_properties #(.WDT_CYCLES(WDT_CYCLES)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .host_chip_select_n(host_chip_select_n),
  .host_data_out(host_data_out), .aux_pin_three_o(aux_pin_three_o),
  .aux_pin_three_oe(aux_pin_three_oe), .aux_pin_four_o(aux_pin_four_o),
  .aux_pin_four_oe(aux_pin_four_oe), .aux_pin_five_o(aux_pin_five_o),
  .aux_pin_five_oe(aux_pin_five_oe));
